/* core/ext_edge_interrupt_unit.sv */
// The implementer's own choice: the APB interface to the registers.
`default_nettype none

// What this block does
// - Selected pin edge raises a request
// - Select 1 falling, 0 rising, per pin
// - Select change can itself raise request
// - Level register shows both pin levels
// - Levels track pins whatever else happens
// - Request flags sticky until software clears
// - Timer requests every 250/100/5/1 ms
// - Serial transfer completion raises request
// - Frequency count completion raises request
// - Pins pass input latch first
// - Pulses under 1 us are rejected
module ext_edge_interrupt_unit
  import ext_irq_pkg::*;
#(
  parameter int CYC_PER_MS = CYC_PER_MS_DEF
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic CE_RESET,
  input wire logic CLK_STOP_RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [DATA_W-1:0] PWDATA,
  output logic [DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EXT_IRQ_PIN_A,
  input wire logic EXT_IRQ_PIN_B,
  input wire logic SERIAL_DONE,
  input wire logic FREQ_COUNT_DONE,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  apb_state_e apb_q;
  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] pin_latch_q;
  logic [NUM_PINS-1:0] level;
  logic [NUM_PINS-1:0] polarity_sel_q;
  logic [NUM_PINS-1:0] eff;
  logic [NUM_PINS-1:0] eff_prev_q;
  logic [NUM_PINS-1:0] pin_edge;
  logic [NUM_SRC-1:0] status_q;
  logic [NUM_SRC-1:0] enable_q;
  logic [NUM_SRC-1:0] events;
  logic [NUM_SRC-1:0] clear_mask;
  logic [TSEL_W-1:0] tsel_q;
  logic timer_tick;
  logic setup;
  logic commit_wr;
  logic mapped;
  logic [DATA_W-1:0] rdata;

  // Address match against a register index
  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [IDX_W-1:0] idx);
    hit = (addr == {idx, 2'b00});
  endfunction : hit

  // ----------------------------------------------------------------
  // Pin input path
  // ----------------------------------------------------------------
  assign pin_raw = {EXT_IRQ_PIN_B, EXT_IRQ_PIN_A};

  // Input latch ahead of both the filter and the edge detector
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      pin_latch_q <= '0;
    end else begin
      pin_latch_q <= pin_raw;
    end
  end

  // One noise filter per pin; filtered level drives everything after
  generate
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      pulse_reject_filter u_filt (
        .clk(CLK_SYS),
        .rst(RESET),
        .din(pin_latch_q[i]),
        .dout(level[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  // Folding the select into the level turns a falling edge into a
  // rising one, so a select flip with the pin at the wrong level
  // looks like an edge too, exactly as software must expect.
  assign eff = level ^ polarity_sel_q;
  assign pin_edge = eff & ~eff_prev_q;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      eff_prev_q <= '0;
    end else begin
      eff_prev_q <= eff;
    end
  end

  // ----------------------------------------------------------------
  // Internal sources
  // ----------------------------------------------------------------
  interval_timer #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_timer (
    .clk(CLK_SYS),
    .rst(RESET),
    .sel(tsel_q),
    .tick(timer_tick)
  );

  // Serial and counter pulses arrive already in the system clock
  always_comb begin
    events = '0;
    events[ST_PIN_A] = pin_edge[0];
    events[ST_PIN_B] = pin_edge[1];
    events[ST_TIMER] = timer_tick;
    events[ST_SERIAL] = SERIAL_DONE;
    events[ST_FREQ] = FREQ_COUNT_DONE;
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign setup = PSEL & ~PENABLE;
  assign PREADY = (apb_q == APB_ACCESS);
  assign commit_wr = PSEL & PENABLE & PREADY & PWRITE;

  always_comb begin
    mapped = hit(PADDR, IDX_PIN_LEVEL) | hit(PADDR, IDX_EDGE_SEL) |
             hit(PADDR, IDX_IRQ_STATUS) | hit(PADDR, IDX_IRQ_CLEAR) |
             hit(PADDR, IDX_IRQ_ENABLE) | hit(PADDR, IDX_TIMER_SEL);
  end

  // Read mux; unused upper bits read zero
  always_comb begin
    rdata = '0;
    if (hit(PADDR, IDX_PIN_LEVEL)) begin
      rdata[NUM_PINS-1:0] = level;
    end else if (hit(PADDR, IDX_EDGE_SEL)) begin
      rdata[NUM_PINS-1:0] = polarity_sel_q;
    end else if (hit(PADDR, IDX_IRQ_STATUS)) begin
      rdata[NUM_SRC-1:0] = status_q;
    end else if (hit(PADDR, IDX_IRQ_ENABLE)) begin
      rdata[NUM_SRC-1:0] = enable_q;
    end else if (hit(PADDR, IDX_TIMER_SEL)) begin
      rdata[TSEL_W-1:0] = tsel_q;
    end
  end

  // One wait-free access: data is captured in setup, ready in access
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      apb_q <= APB_IDLE;
    end else begin
      case (apb_q)
        APB_IDLE: apb_q <= setup ? APB_ACCESS : APB_IDLE;
        APB_ACCESS: apb_q <= APB_IDLE;
        default: apb_q <= APB_IDLE;
      endcase
    end
  end

  // Read data and error come from flops loaded in the setup cycle
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      PRDATA <= '0;
      PSLVERR <= 1'b0;
    end else if (setup) begin
      PRDATA <= PWRITE ? '0 : rdata;
      PSLVERR <= ~mapped;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Any of the three chip resets returns both pins to rising edge
  always_ff @(posedge CLK_SYS) begin
    if (RESET || CE_RESET || CLK_STOP_RESET) begin
      polarity_sel_q <= EDGE_SEL_RST;
    end else if (commit_wr && hit(PADDR, IDX_EDGE_SEL)) begin
      polarity_sel_q <= PWDATA[NUM_PINS-1:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      enable_q <= IRQ_EN_RST;
    end else if (commit_wr && hit(PADDR, IDX_IRQ_ENABLE)) begin
      enable_q <= PWDATA[NUM_SRC-1:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      tsel_q <= TSEL_RST;
    end else if (commit_wr && hit(PADDR, IDX_TIMER_SEL)) begin
      tsel_q <= PWDATA[TSEL_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Sticky request flags
  // ----------------------------------------------------------------
  assign clear_mask = (commit_wr && hit(PADDR, IDX_IRQ_CLEAR)) ?
                      PWDATA[NUM_SRC-1:0] : '0;

  // Set regardless of enable; a same-cycle event beats the clear
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~clear_mask) | events;
    end
  end

  assign IRQ = |(status_q & enable_q);

endmodule : ext_edge_interrupt_unit

`default_nettype wire

/* core/ext_irq_pkg.sv */
`default_nettype none

package ext_irq_pkg;

  // ----------------------------------------------------------------
  // Bus layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int IDX_W = 8;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PIN_LEVEL = 8'h0f;
  localparam logic [IDX_W-1:0] IDX_EDGE_SEL = 8'h1f;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 8'h20;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR = 8'h21;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 8'h22;
  localparam logic [IDX_W-1:0] IDX_TIMER_SEL = 8'h23;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int NUM_PINS = 2;
  localparam int NUM_SRC = 5;
  localparam int ST_PIN_A = 0;
  localparam int ST_PIN_B = 1;
  localparam int ST_TIMER = 2;
  localparam int ST_SERIAL = 3;
  localparam int ST_FREQ = 4;
  localparam int TSEL_W = 2;

  // Reset values
  localparam logic [NUM_PINS-1:0] EDGE_SEL_RST = 2'h0;
  localparam logic [NUM_SRC-1:0] IRQ_EN_RST = 5'h00;
  localparam logic [TSEL_W-1:0] TSEL_RST = 2'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int FILTER_MIN_NS = 1000;
  localparam int FILTER_CYC =
    (FILTER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_CNT_W = 5;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int PRESC_W = 16;
  localparam int MS_CNT_W = 8;

  // Timer intervals in milliseconds
  localparam int TMR_250_MS = 250;
  localparam int TMR_100_MS = 100;
  localparam int TMR_5_MS = 5;
  localparam int TMR_1_MS = 1;

  typedef enum logic [1:0] {
    TSEL_250 = 2'b00,
    TSEL_100 = 2'b01,
    TSEL_5 = 2'b10,
    TSEL_1 = 2'b11
  } tsel_e;

  typedef enum logic {
    APB_IDLE = 1'b0,
    APB_ACCESS = 1'b1
  } apb_state_e;

endpackage : ext_irq_pkg

`default_nettype wire

/* core/interval_timer.sv */
`default_nettype none

// Periodic tick with one of four millisecond intervals
module interval_timer
  import ext_irq_pkg::*;
#(
  parameter int CYC_PER_MS = CYC_PER_MS_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [TSEL_W-1:0] sel,
  output logic tick
);

  logic [PRESC_W-1:0] presc_q;
  logic [MS_CNT_W-1:0] ms_q;
  logic [MS_CNT_W-1:0] ms_last;
  logic [TSEL_W-1:0] sel_q;
  logic ms_tick;

  // ----------------------------------------------------------------
  // Interval decode
  // ----------------------------------------------------------------
  always_comb begin
    case (tsel_e'(sel))
      TSEL_250: ms_last = MS_CNT_W'(TMR_250_MS - 1);
      TSEL_100: ms_last = MS_CNT_W'(TMR_100_MS - 1);
      TSEL_5: ms_last = MS_CNT_W'(TMR_5_MS - 1);
      TSEL_1: ms_last = MS_CNT_W'(TMR_1_MS - 1);
      default: ms_last = MS_CNT_W'(TMR_1_MS - 1);
    endcase
  end

  assign ms_tick = (presc_q == PRESC_W'(CYC_PER_MS - 1));

  // ----------------------------------------------------------------
  // Counters; a new interval restarts the period cleanly
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || sel != sel_q) begin
      presc_q <= '0;
      ms_q <= '0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (ms_tick) begin
        presc_q <= '0;
        if (ms_q == ms_last) begin
          ms_q <= '0;
          tick <= 1'b1;
        end else begin
          ms_q <= ms_q + 1'b1;
        end
      end else begin
        presc_q <= presc_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sel_q <= TSEL_RST;
    end else begin
      sel_q <= sel;
    end
  end

endmodule : interval_timer

`default_nettype wire

/* core/pulse_reject_filter.sv */
`default_nettype none

// Passes a level only after it has been stable for FILTER_CYC clocks
module pulse_reject_filter
  import ext_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);

  logic [FILT_CNT_W-1:0] cnt_q;

  // ----------------------------------------------------------------
  // Stability counter
  // ----------------------------------------------------------------
  // Any bounce restarts the count, so short pulses never reach dout
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      dout <= 1'b0;
    end else if (din == dout) begin
      cnt_q <= '0;
    end else if (cnt_q == FILT_CNT_W'(FILTER_CYC - 1)) begin
      cnt_q <= '0;
      dout <= din;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule : pulse_reject_filter

`default_nettype wire

/* sim/ext_edge_interrupt_unit_properties.sv */
`default_nettype none
// ------
// Port checks of the edge interrupt unit
// ------
module eiu_properties
  import ext_irq_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [DATA_W-1:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic EXT_IRQ_PIN_A,
  input wire logic IRQ
);
  logic pin_q;
  logic [4:0] stab_q;
  // Previous pin sample
  always_ff @(posedge CLK_SYS) pin_q <= EXT_IRQ_PIN_A;
  // Quiet time of pin A; saturates well past the noise filter span
  always_ff @(posedge CLK_SYS) begin
    if (RESET || EXT_IRQ_PIN_A != pin_q) begin
      stab_q <= 5'h00;
    end else if (stab_q != 5'h1f) begin
      stab_q <= stab_q + 5'h01;
    end
  end
  default clocking dc @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // Setup cycle, and a read setup aimed at one word
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence read_at_s(logic [9:0] a);
    setup_s ##0 (!PWRITE && PADDR == a);
  endsequence
  chk_ready_setup: assert property (setup_s |=> PREADY)
    else $error("ready missing after setup");
  chk_ready_idle: assert property (!PSEL |-> !PREADY)
    else $error("ready while idle");
  chk_ready_once: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  chk_err_unmapped: assert property (
    setup_s ##0 PADDR == 10'h3fc |=> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped word not refused");
  chk_level_upper: assert property (
    read_at_s(10'h03c) |=> !PSLVERR && PRDATA[31:2] == 30'h0)
    else $error("level word upper bits set");
  chk_level_track: assert property (
    read_at_s(10'h03c) ##0 stab_q == 5'h1f
    |=> PRDATA[0] == $past(EXT_IRQ_PIN_A))
    else $error("level bit does not follow pin");
  chk_irq_reset: assert property (
    disable iff (1'b0) RESET |=> !IRQ)
    else $error("interrupt up after reset");
  chk_irq_sticky: assert property (
    $fell(IRQ) |-> $past(PSEL && PENABLE && PWRITE))
    else $error("interrupt dropped without a write");
endmodule : eiu_properties
bind ext_edge_interrupt_unit eiu_properties chk (.CLK_SYS, .RESET,
  .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR,
  .EXT_IRQ_PIN_A, .IRQ);
`default_nettype wire

/* sim/ext_edge_interrupt_unit_tb.sv */
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  miscompares++; $display("wrong value at %0t: %h, expected %h", \
  $time, a, b); end end
module ext_edge_interrupt_unit_tb
  import ext_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CPM = 10;
  localparam logic [32:0] ALL = {33{1'b1}};
  logic clk = 1'b0, rst = 1'b1, ce_r = 1'b0, cs_r = 1'b0, ser = 1'b0;
  logic frq = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [ADDR_W-1:0] padr = '0;
  logic [DATA_W-1:0] pwd = '0, prd;
  logic prdy, perr, irq, pa, pb;
  logic [1:0] lvl = 2'h0, sel = 2'h0;
  logic [4:0] st = 5'h0;
  logic [32:0] eq[$], mq[$];
  int miscompares = 0, checks_done = 0, seed = 45, n;
  int tms[4] = '{TMR_250_MS, TMR_100_MS, TMR_5_MS, TMR_1_MS};
  ext_edge_interrupt_unit #(.CYC_PER_MS(CPM)) DUT (.CLK_SYS(clk),
    .RESET(rst), .CE_RESET(ce_r), .CLK_STOP_RESET(cs_r), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd),
    .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .EXT_IRQ_PIN_A(pa),
    .EXT_IRQ_PIN_B(pb), .SERIAL_DONE(ser), .FREQ_COUNT_DONE(frq),
    .IRQ(irq));
  pin_source src (.clk(clk), .pin_a(pa), .pin_b(pb));
  // ------
  // Tasks
  // ------
  task automatic test_done;
    $display("mismatches %0d, checks %0d", miscompares, checks_done);
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc
  // One transfer; a read leaves its expectation and mask in the queue
  task automatic bus(input logic w, input logic [7:0] i,
      input logic [31:0] d, input logic [32:0] e = '0,
      input logic [32:0] m = '0);
    if (!w) begin
      eq.push_back(e);
      mq.push_back(m);
    end
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    padr <= {i, 2'b00};
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Ready is combinational from a flop: look mid-cycle, finish on edge
    do @(negedge clk); while (prdy !== 1'b1);
    @(posedge clk);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : bus
  // Pins move; the model marks the edges that the selects ask for
  task automatic pins(input logic [1:0] v);
    st[1:0] |= (v & ~lvl & ~sel) | (~v & lvl & sel);
    lvl = v;
    src.set(v);
    cyc(35);
  endtask : pins
  // Select change alone may raise a request
  task automatic edge_w(input logic [1:0] v);
    st[1:0] |= (lvl & sel & ~v) | (~lvl & ~sel & v);
    sel = v;
    bus(1'b1, IDX_EDGE_SEL, {30'h0, v});
    cyc(2);
  endtask : edge_w
  // Clock, and a watchdog well beyond the planned run
  initial forever #20 clk = ~clk;
  initial begin
    cyc(20000);
    miscompares++;
    test_done;
  end
  // Oldest note against each completed read, sampled mid access cycle
  always @(negedge clk) begin
    if (psel && pen && prdy && !pwr) begin
      `CHK({perr, prd} & mq[0], eq[0] & mq[0])
      void'(eq.pop_front());
      void'(mq.pop_front());
    end
  end
  // ------
  // Scenarios
  // ------
  initial begin
    cyc(6);
    rst <= 1'b0;
    bus(1'b0, IDX_EDGE_SEL, 32'h0, 33'h0, ALL);
    bus(1'b0, IDX_PIN_LEVEL, 32'h0, 33'h0, ALL);
    bus(1'b0, 8'hff, 32'h0, {1'b1, 32'h0}, ALL);
    bus(1'b1, IDX_IRQ_ENABLE, 32'h1f);
    repeat (14) begin
      if ($random(seed) & 1) edge_w(2'($random(seed)));
      else pins(2'($random(seed)));
      bus(1'b0, IDX_IRQ_STATUS, 32'h0, {28'h0, st}, 33'h3);
      bus(1'b0, IDX_PIN_LEVEL, 32'h0, {31'h0, lvl}, ALL);
      if ($random(seed) & 1) begin
        bus(1'b1, IDX_IRQ_CLEAR, 32'h3);
        st = 5'h0;
      end
    end
    src.spike(10);
    cyc(35);
    bus(1'b0, IDX_IRQ_STATUS, 32'h0, {28'h0, st}, 33'h3);
    bus(1'b0, IDX_PIN_LEVEL, 32'h0, {31'h0, lvl}, ALL);
    // Every interval: quiet just before it ends, flagged just after
    // Leave the reset interval first, so the first pass restarts it
    bus(1'b1, IDX_TIMER_SEL, 32'h3);
    for (int k = 0; k < 4; k++) begin
      n = tms[k] * CPM;
      bus(1'b1, IDX_TIMER_SEL, 32'(k));
      bus(1'b1, IDX_IRQ_CLEAR, 32'h1f);
      cyc(n - 8);
      bus(1'b0, IDX_IRQ_STATUS, 32'h0, 33'h0, 33'h4);
      cyc(8);
      bus(1'b0, IDX_IRQ_STATUS, 32'h0, 33'h4, 33'h4);
    end
    bus(1'b1, IDX_IRQ_ENABLE, 32'h08);
    bus(1'b1, IDX_IRQ_CLEAR, 32'h1f);
    cyc(2);
    @(negedge clk) `CHK(irq, 1'b0)
    @(posedge clk) ser <= 1'b1;
    @(posedge clk) ser <= 1'b0;
    cyc(2);
    @(negedge clk) `CHK(irq, 1'b1)
    @(posedge clk) frq <= 1'b1;
    @(posedge clk) frq <= 1'b0;
    bus(1'b0, IDX_IRQ_STATUS, 32'h0, 33'h18, 33'h18);
    bus(1'b1, IDX_IRQ_CLEAR, 32'h08);
    cyc(2);
    @(negedge clk) `CHK(irq, 1'b0)
    bus(1'b1, IDX_IRQ_ENABLE, 32'h10);
    cyc(2);
    @(negedge clk) `CHK(irq, 1'b1)
    pins(2'h0);
    edge_w(2'h3);
    ce_r <= 1'b1;
    @(posedge clk) ce_r <= 1'b0;
    sel = 2'h0;
    bus(1'b0, IDX_EDGE_SEL, 32'h0, 33'h0, 33'h3);
    edge_w(2'h3);
    cs_r <= 1'b1;
    @(posedge clk) cs_r <= 1'b0;
    sel = 2'h0;
    bus(1'b0, IDX_EDGE_SEL, 32'h0, 33'h0, 33'h3);
    cyc(5);
    test_done;
  end
endmodule : ext_edge_interrupt_unit_tb
`default_nettype wire

/* sim/pin_source.sv */
`default_nettype none
// External signal source on both pins; always driven, no pull
module pin_source (
  input wire logic clk,
  output logic pin_a,
  output logic pin_b
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  // New levels just after an edge
  task automatic set(input logic [1:0] v);
    @(posedge clk);
    pin_a <= v[0];
    pin_b <= v[1];
  endtask : set
  // Spike on pin A shorter than the noise limit
  task automatic spike(input int n);
    @(posedge clk);
    pin_a <= ~pin_a;
    repeat (n) @(posedge clk);
    pin_a <= ~pin_a;
  endtask : spike
endmodule : pin_source
`default_nettype wire
